// file: plc_checker.sv
// port assertions for the position list compare block
`timescale 1ns/100ps
`include "plc_defs.vh"

module plc_checker
(
    // clock and reset
    input wire sys_clk,
    input wire resetn,
    // register port
    input wire [`PLC_AW-1:0] reg_addr,
    input wire [`PLC_DW-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [`PLC_DW-1:0] reg_rdata_q,
    // motion side
    input wire [2:0] op_mode,
    input wire [`PLC_POS_W-1:0] prof_pos,
    input wire [`PLC_POS_W-1:0] act_pos,
    // results
    input wire [`PLC_ACT_W-1:0] speed_setpoint_q,
    input wire speed_load_q,
    input wire trigger_o_q,
    input wire trigger_oe_q,
    input wire list_done_q
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    // select writes decoded once for the start and stop checks
    wire sel_wr = reg_wr && reg_addr == `PLC_ADDR_SEL;
    wire go_wr = sel_wr && (reg_wdata[1:0] == `PLC_SEL_L1 ||
        reg_wdata[1:0] == `PLC_SEL_L2);

    trig_low_a: assert property (trigger_o_q == 1'b0)
        else $error("trigger value not low");
    set_hold_a: assert property (
        $changed(speed_setpoint_q) |-> speed_load_q)
        else $error("setpoint moved without a load");
    load_mode_a: assert property (
        speed_load_q |-> ($past(op_mode) == `PLC_MODE_SPEED ||
            $past(op_mode) == `PLC_MODE_PTP))
        else $error("speed applied in a wrong mode");
    load_run_a: assert property (speed_load_q |-> !$past(list_done_q))
        else $error("speed applied while idle");
    trig_mode_a: assert property (
        $changed(trigger_oe_q) |-> ($past(op_mode) != `PLC_MODE_NONE &&
            $past(op_mode) <= `PLC_MODE_OSC))
        else $error("trigger moved in a wrong mode");
    trig_run_a: assert property (
        $changed(trigger_oe_q) |-> !$past(list_done_q))
        else $error("trigger moved while idle");
    stop_done_a: assert property (
        sel_wr && reg_wdata[1:0] == `PLC_SEL_NONE |-> ##[1:2] list_done_q)
        else $error("stop did not end processing");
    done_fall_a: assert property (
        $fell(list_done_q) |-> $past(go_wr))
        else $error("processing began without a select");
endmodule

bind plc_top plc_checker u_chk (.*);

// file: plc_cross.v
// crossing detector between two consecutive position samples
`timescale 1ns/100ps
`include "plc_defs.vh"

module plc_cross
(
    // samples and target
    input wire signed [`PLC_POS_W-1:0] prev_pos,
    input wire signed [`PLC_POS_W-1:0] cur_pos,
    input wire signed [`PLC_POS_W-1:0] target,
    // result
    output wire hit
);

    // target lies within the closed span lo..hi
    function plc_between;
        input signed [`PLC_POS_W-1:0] lo;
        input signed [`PLC_POS_W-1:0] hi;
        input signed [`PLC_POS_W-1:0] t;
        begin
            plc_between = (lo <= t) && (t <= hi);
        end
    endfunction

    // reached or passed, in either direction of travel
    assign hit = plc_between(prev_pos, cur_pos, target) | // R16
                 plc_between(cur_pos, prev_pos, target);  // R16
endmodule

// file: plc_defs.vh
// shared constants of the position list compare block
`ifndef PLC_DEFS_VH
`define PLC_DEFS_VH

// ----------------------------------------
// register word addresses
// ----------------------------------------
`define PLC_AW 4
`define PLC_ADDR_SEL 4'h0
`define PLC_ADDR_TYPE 4'h1
`define PLC_ADDR_START1 4'h2
`define PLC_ADDR_FINISH1 4'h3
`define PLC_ADDR_START2 4'h4
`define PLC_ADDR_FINISH2 4'h5
`define PLC_ADDR_EIDX 4'h6
`define PLC_ADDR_EPOS 4'h7
`define PLC_ADDR_EACT 4'h8
`define PLC_ADDR_STATE 4'h9
`define PLC_ADDR_LAST 4'ha

// ----------------------------------------
// widths and field values
// ----------------------------------------
`define PLC_DW 32
`define PLC_IDX_W 6
`define PLC_POS_W 32
`define PLC_ACT_W 16
`define PLC_IDX_ONE 6'h01
`define PLC_IDX_ZERO 6'h00
`define PLC_IDX_PAD 10'h000
`define PLC_PAD16 16'h0000
`define PLC_PAD12 12'h000
`define PLC_PAD25 25'h0000000
`define PLC_PAD30 30'h00000000
`define PLC_PAD26 26'h0000000
`define PLC_ZERO32 32'h00000000
`define PLC_ZERO16 16'h0000
`define PLC_NO_ENTRY 16'hffff
`define PLC_EIDX_LIST 6

// list select codes
`define PLC_SEL_NONE 2'h0
`define PLC_SEL_L1 2'h1
`define PLC_SEL_L2 2'h2

// list type values
`define PLC_TYPE_SPEED 1'b0
`define PLC_TYPE_SIGNAL 1'b1

// operating mode codes
`define PLC_MODE_NONE 3'h0
`define PLC_MODE_MANUAL 3'h1
`define PLC_MODE_SPEED 3'h2
`define PLC_MODE_PTP 3'h3
`define PLC_MODE_GEAR 3'h4
`define PLC_MODE_OSC 3'h5

// status word bit positions
`define PLC_BIT_ERR 15
`define PLC_BIT_QUIT 14
`endif

// file: plc_list_mem.v
// two 64 entry lists of position and action values
`timescale 1ns/100ps
`include "plc_defs.vh"

module plc_list_mem
(
    // clock
    input wire sys_clk,
    // write port
    input wire wr_en,
    input wire wr_list,
    input wire [`PLC_IDX_W-1:0] wr_idx,
    input wire [`PLC_POS_W-1:0] wr_pos,
    input wire [`PLC_ACT_W-1:0] wr_act,
    // compare read port
    input wire a_list,
    input wire [`PLC_IDX_W-1:0] a_idx,
    output wire [`PLC_POS_W-1:0] a_pos,
    output wire [`PLC_ACT_W-1:0] a_act,
    // bus read port
    input wire b_list,
    input wire [`PLC_IDX_W-1:0] b_idx,
    output wire [`PLC_POS_W-1:0] b_pos,
    output wire [`PLC_ACT_W-1:0] b_act
);

    // list number is the top address bit
    reg [`PLC_POS_W-1:0] pos_mem [0:127];
    reg [`PLC_ACT_W-1:0] act_mem [0:127];

    // entries keep their contents across stops
    always @(posedge sys_clk)
    begin
        if (wr_en)
        begin
            pos_mem[{wr_list, wr_idx}] <= wr_pos; // R1
            act_mem[{wr_list, wr_idx}] <= wr_act; // R1
        end
    end

    // asynchronous reads, so the engine sees its entry at once
    assign a_pos = pos_mem[{a_list, a_idx}];
    assign a_act = act_mem[{a_list, a_idx}];
    assign b_pos = pos_mem[{b_list, b_idx}];
    assign b_act = act_mem[{b_list, b_idx}];
endmodule

// file: plc_motion.sv
// motion profile stand-in that feeds positions and mode
`timescale 1ns/100ps
`include "plc_defs.vh"

module plc_motion
(
    // clock and reset
    input wire sys_clk,
    input wire resetn,
    // bench commands
    input wire signed [`PLC_POS_W-1:0] tgt,
    input wire [2:0] mode_cmd,
    // toward the block
    output reg [2:0] op_mode,
    output reg signed [`PLC_POS_W-1:0] prof_pos,
    output reg signed [`PLC_POS_W-1:0] act_pos
);
    // ramp in steps of 10 so entries on multiples of 10 are hit exactly; axis trails
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            op_mode <= `PLC_MODE_NONE;
            prof_pos <= `PLC_ZERO32;
            act_pos <= `PLC_ZERO32;
        end
        else
        begin
            op_mode <= mode_cmd;
            act_pos <= prof_pos;
            if (prof_pos < tgt)
                prof_pos <= prof_pos + 32'h0000000a;
            else if (prof_pos > tgt)
                prof_pos <= prof_pos - 32'h0000000a;
        end
    end
endmodule

// file: plc_top.v
// position list compare engine with its register port
`timescale 1ns/100ps
`include "plc_defs.vh"

// What this block does
// R1: keeps two lists of 64 entries, each a position plus an action
// R2: software sets a list type before writing its entries
// R3: speed lists set speed, run in speed and point-to-point, profile position
// R4: signal lists set trigger, run in five modes, compare actual position
// R5: only signal lists drive trigger, either low or released
// R6: on a position match in an allowed mode, the entry action is applied
// R7: selecting a list starts comparing from its start index
// R8: selecting the other list while running continues on that list
// R9: deselecting the list stops processing at once
// R10: processing ends after the finish index entry is applied
// R11: indices and entries stay after a stop, reselecting restarts
// R12: status bit 14 is 0 while running, 1 once done
// R13: last entry index reads -1 until an entry applies, then its index
// R14: comparing runs beside motion and never alters the move command
// R15: select code 0 none, 1 first list, 2 second list
// R16: reaching or passing an entry applies it once, then the pointer moves
module plc_top
(
    // clock and reset
    input wire sys_clk,
    input wire resetn,
    // register port
    input wire [`PLC_AW-1:0] reg_addr,
    input wire [`PLC_DW-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [`PLC_DW-1:0] reg_rdata_q,
    // motion side, same clock
    input wire [2:0] op_mode,
    input wire [`PLC_POS_W-1:0] prof_pos,
    input wire [`PLC_POS_W-1:0] act_pos,
    // results
    output reg [`PLC_ACT_W-1:0] speed_setpoint_q,
    output reg speed_load_q,
    output reg trigger_o_q,
    output reg trigger_oe_q,
    output reg list_done_q
);

    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_ARM = 3'b010;
    localparam ST_RUN = 3'b100;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // list types accept only their own operating modes
    function plc_mode_ok;
        input list_type;
        input [2:0] mode;
        begin
            if (list_type == `PLC_TYPE_SPEED)
                plc_mode_ok = (mode == `PLC_MODE_SPEED) || // R3
                              (mode == `PLC_MODE_PTP);     // R3
            else
                plc_mode_ok = (mode == `PLC_MODE_MANUAL) || // R4
                              (mode == `PLC_MODE_SPEED) ||  // R4
                              (mode == `PLC_MODE_PTP) ||    // R4
                              (mode == `PLC_MODE_GEAR) ||   // R4
                              (mode == `PLC_MODE_OSC);      // R4
        end
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [1:0] sel_q;
    reg [1:0] type_q;
    reg [`PLC_IDX_W-1:0] start1_q;
    reg [`PLC_IDX_W-1:0] finish1_q;
    reg [`PLC_IDX_W-1:0] start2_q;
    reg [`PLC_IDX_W-1:0] finish2_q;
    reg [`PLC_IDX_W:0] eidx_q;
    reg [`PLC_POS_W-1:0] epos_q;
    reg [2:0] state_q;
    reg act_list_q;
    reg [`PLC_IDX_W-1:0] ptr_q;
    reg [`PLC_POS_W-1:0] prev_q;
    reg err_q;
    reg [`PLC_ACT_W-1:0] last_q;

    wire [`PLC_POS_W-1:0] ent_pos;
    wire [`PLC_ACT_W-1:0] ent_act;
    wire [`PLC_POS_W-1:0] rd_pos;
    wire [`PLC_ACT_W-1:0] rd_act;
    wire hit;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire wr_sel = reg_wr && (reg_addr == `PLC_ADDR_SEL);
    wire wr_ent = reg_wr && (reg_addr == `PLC_ADDR_EACT);
    wire [1:0] sel_v = reg_wdata[1:0];
    wire new_list = (sel_v == `PLC_SEL_L2);
    wire start_ok = wr_sel && (new_list || (sel_v == `PLC_SEL_L1)) &&
        (new_start <= new_finish);
    wire [`PLC_IDX_W-1:0] new_start = new_list ? start2_q : start1_q;
    wire [`PLC_IDX_W-1:0] new_finish = new_list ? finish2_q : finish1_q;
    wire act_type = type_q[act_list_q];
    wire [`PLC_IDX_W-1:0] act_finish = act_list_q ? finish2_q : finish1_q;
    // speed lists follow the profile, signal lists the real axis
    wire [`PLC_POS_W-1:0] cmp_pos =
        (act_type == `PLC_TYPE_SPEED) ? prof_pos : act_pos; // R3 R4
    wire apply = (state_q == ST_RUN) && hit &&
                 plc_mode_ok(act_type, op_mode); // R6

    // ----------------------------------------
    // list storage and match
    // ----------------------------------------
    plc_list_mem u_mem
    (
        .sys_clk(sys_clk),
        .wr_en(wr_ent),
        .wr_list(eidx_q[`PLC_EIDX_LIST]),
        .wr_idx(eidx_q[`PLC_IDX_W-1:0]),
        .wr_pos(epos_q),
        .wr_act(reg_wdata[`PLC_ACT_W-1:0]),
        .a_list(act_list_q),
        .a_idx(ptr_q),
        .a_pos(ent_pos),
        .a_act(ent_act),
        .b_list(eidx_q[`PLC_EIDX_LIST]),
        .b_idx(eidx_q[`PLC_IDX_W-1:0]),
        .b_pos(rd_pos),
        .b_act(rd_act)
    );

    plc_cross u_cross
    (
        .prev_pos(prev_q),
        .cur_pos(cmp_pos),
        .target(ent_pos),
        .hit(hit)
    );

    // ----------------------------------------
    // configuration writes
    // ----------------------------------------
    // entry data is staged, the action write commits both words;
    // the type must already be set since it picks the meaning
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            type_q <= {`PLC_TYPE_SPEED, `PLC_TYPE_SPEED};
            start1_q <= `PLC_IDX_ZERO;
            finish1_q <= `PLC_IDX_ZERO;
            start2_q <= `PLC_IDX_ZERO;
            finish2_q <= `PLC_IDX_ZERO;
            eidx_q <= {1'b0, `PLC_IDX_ZERO};
            epos_q <= `PLC_ZERO32;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `PLC_ADDR_TYPE: type_q <= reg_wdata[1:0]; // R2
                `PLC_ADDR_START1: start1_q <= reg_wdata[`PLC_IDX_W-1:0];
                `PLC_ADDR_FINISH1: finish1_q <= reg_wdata[`PLC_IDX_W-1:0];
                `PLC_ADDR_START2: start2_q <= reg_wdata[`PLC_IDX_W-1:0];
                `PLC_ADDR_FINISH2: finish2_q <= reg_wdata[`PLC_IDX_W-1:0];
                `PLC_ADDR_EIDX: eidx_q <= reg_wdata[`PLC_IDX_W:0];
                `PLC_ADDR_EPOS: epos_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // list engine
    // ----------------------------------------
    // a select write always wins over the running step
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sel_q <= `PLC_SEL_NONE;
            state_q <= ST_IDLE;
            act_list_q <= 1'b0;
            ptr_q <= `PLC_IDX_ZERO;
            prev_q <= `PLC_ZERO32;
            err_q <= 1'b0;
            last_q <= `PLC_NO_ENTRY; // R13
        end
        else if (wr_sel)
        begin
            sel_q <= sel_v; // R15
            if ((sel_v != `PLC_SEL_L1) && (sel_v != `PLC_SEL_L2))
            begin
                state_q <= ST_IDLE; // R9
            end
            else if (new_start > new_finish)
            begin
                // bad range: refuse and flag
                err_q <= 1'b1;
                state_q <= ST_IDLE;
            end
            else
            begin
                err_q <= 1'b0;
                act_list_q <= new_list; // R8
                ptr_q <= new_start; // R7 R11
                state_q <= ST_ARM; // R7
                if (state_q == ST_IDLE)
                    last_q <= `PLC_NO_ENTRY; // R13
            end
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    prev_q <= cmp_pos;
                end
                ST_ARM:
                begin
                    // first sample, an entry right here still matches
                    prev_q <= cmp_pos;
                    state_q <= ST_RUN;
                end
                ST_RUN:
                begin
                    if (apply)
                    begin
                        // prev kept, so entries passed in one step
                        // are still applied one per cycle
                        last_q <= {`PLC_IDX_PAD, ptr_q}; // R13
                        if (ptr_q == act_finish)
                            state_q <= ST_IDLE; // R10
                        else
                            ptr_q <= ptr_q + `PLC_IDX_ONE; // R16
                    end
                    else
                    begin
                        prev_q <= cmp_pos;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // action outputs
    // ----------------------------------------
    // outputs sit beside the move; nothing here feeds the profile back
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            speed_setpoint_q <= `PLC_ZERO16;
            speed_load_q <= 1'b0;
            trigger_o_q <= 1'b0;
            trigger_oe_q <= 1'b0;
        end
        else
        begin
            speed_load_q <= 1'b0;
            trigger_o_q <= 1'b0; // R5
            if (apply && !wr_sel)
            begin
                if (act_type == `PLC_TYPE_SPEED)
                begin
                    speed_setpoint_q <= ent_act; // R3 R6 R14
                    speed_load_q <= 1'b1; // R6
                end
                else
                begin
                    // bit 0 of the action clear pulls low, bit 0 set releases
                    trigger_oe_q <= ~ent_act[0]; // R5 R6
                end
            end
        end
    end

    // ----------------------------------------
    // status
    // ----------------------------------------
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            list_done_q <= 1'b1;
        else
            list_done_q <= wr_sel ? !start_ok : (state_q == ST_IDLE); // R12
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    // data stands for one cycle after the strobe, else zero
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata_q <= `PLC_ZERO32;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                `PLC_ADDR_SEL: reg_rdata_q <= {`PLC_PAD30, sel_q};
                `PLC_ADDR_TYPE: reg_rdata_q <= {`PLC_PAD30, type_q};
                `PLC_ADDR_START1:
                    reg_rdata_q <= {`PLC_PAD26, start1_q};
                `PLC_ADDR_FINISH1:
                    reg_rdata_q <= {`PLC_PAD26, finish1_q};
                `PLC_ADDR_START2:
                    reg_rdata_q <= {`PLC_PAD26, start2_q};
                `PLC_ADDR_FINISH2:
                    reg_rdata_q <= {`PLC_PAD26, finish2_q};
                `PLC_ADDR_EIDX: reg_rdata_q <= {`PLC_PAD25, eidx_q};
                `PLC_ADDR_EPOS: reg_rdata_q <= rd_pos;
                `PLC_ADDR_EACT: reg_rdata_q <= {`PLC_PAD16, rd_act};
                `PLC_ADDR_STATE:
                    reg_rdata_q <= {`PLC_PAD16, err_q,
                                    state_q == ST_IDLE, // R12
                                    `PLC_PAD12,
                                    (state_q == ST_IDLE) ? `PLC_SEL_NONE :
                                    (act_list_q ? `PLC_SEL_L2 :
                                     `PLC_SEL_L1)};
                `PLC_ADDR_LAST: reg_rdata_q <= {`PLC_PAD16, last_q};
                default: reg_rdata_q <= `PLC_ZERO32;
            endcase
        end
        else
        begin
            reg_rdata_q <= `PLC_ZERO32;
        end
    end
endmodule

// file: tb_top.sv
// self-checking bench of the position list compare block
`timescale 1ns/100ps
`include "plc_defs.vh"

module tb_top;
    reg sys_clk = 1'b0;
    reg resetn = 1'b0;
    reg [`PLC_AW-1:0] reg_addr = 4'h0;
    reg [`PLC_DW-1:0] reg_wdata = 32'h00000000;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg signed [31:0] tgt = 32'h00000000;
    reg [2:0] mode_cmd = 3'h0;
    wire [`PLC_DW-1:0] reg_rdata_q;
    wire [2:0] op_mode;
    wire [31:0] prof_pos;
    wire [31:0] act_pos;
    wire [15:0] speed_setpoint_q;
    wire speed_load_q;
    wire trigger_o_q;
    wire trigger_oe_q;
    wire list_done_q;
    integer fails = 0;
    integer comparisons = 0;
    reg [31:0] rv;

    plc_top dut (.*);
    plc_motion u_mot (.*);

    initial
    begin
        forever #10 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task end_sim;
    begin
        if (fails == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
    begin
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask

    task wr(input [3:0] a, input [31:0] d);
    begin
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    end
    endtask

    // read data stand only in the cycle after the strobe
    task rd(input [3:0] a);
    begin
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata_q;
    end
    endtask

    task ent(input l, input [5:0] i, input [31:0] p, input [15:0] ac);
    begin
        wr(`PLC_ADDR_EIDX, {25'h0000000, l, i});
        wr(`PLC_ADDR_EPOS, p);
        wr(`PLC_ADDR_EACT, {16'h0000, ac});
    end
    endtask

    // 0 waits for a load, 1 for idle, 2 for the axis at target
    task wait_for(input [1:0] k);
        integer n;
    begin
        n = 0;
        @(posedge sys_clk);
        #1;
        while (!((k == 0 && speed_load_q === 1'b1) ||
            (k == 1 && list_done_q === 1'b1) ||
            (k == 2 && act_pos === tgt)) && n < 600)
        begin
            @(posedge sys_clk);
            #1 n = n + 1;
        end
        if (n == 600)
        begin
            fails = fails + 1;
            end_sim;
        end
    end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task s_reset;
    begin
        chk(32'(list_done_q), 32'h00000001);
        chk(32'(trigger_oe_q), 32'h00000000);
        rd(`PLC_ADDR_STATE);
        chk(rv, 32'h00004000);
        rd(`PLC_ADDR_LAST);
        chk(rv, 32'h0000ffff);
        rd(4'hf);
        chk(rv, 32'h00000000);
    end
    endtask

    // list one speed, list two signal; the far entry tests index 63
    task s_load;
    begin
        wr(`PLC_ADDR_TYPE, 32'h00000002);
        ent(1'b0, 6'h02, 32'h00000064, 16'h000b);
        ent(1'b0, 6'h03, 32'h000000c8, 16'h0016);
        ent(1'b0, 6'h04, 32'h0000012c, 16'h0021);
        ent(1'b1, 6'h00, 32'h0000044c, 16'h0000);
        ent(1'b1, 6'h01, 32'h000004b0, 16'h0001);
        ent(1'b1, 6'h02, 32'h00001388, 16'h0000);
        ent(1'b1, 6'h3f, 32'h00001e61, 16'h0005);
        rd(`PLC_ADDR_EPOS);
        chk(rv, 32'h00001e61);
        rd(`PLC_ADDR_EACT);
        chk(rv, 32'h00000005);
        wr(`PLC_ADDR_START1, 32'h00000002);
        wr(`PLC_ADDR_FINISH1, 32'h00000004);
        wr(`PLC_ADDR_START2, 32'h00000000);
        wr(`PLC_ADDR_FINISH2, 32'h00000002);
    end
    endtask

    task three_loads;
    begin
        tgt <= 32'h00000190;
        wait_for(0);
        chk(32'(speed_setpoint_q), 32'h0000000b);
        wait_for(0);
        chk(32'(speed_setpoint_q), 32'h00000016);
        wait_for(0);
        chk(32'(speed_setpoint_q), 32'h00000021);
        wait_for(1);
        rd(`PLC_ADDR_LAST);
        chk(rv, 32'h00000004);
    end
    endtask

    task s_speed;
    begin
        mode_cmd <= `PLC_MODE_SPEED;
        wr(`PLC_ADDR_SEL, 32'h00000001);
        rd(`PLC_ADDR_STATE);
        chk(32'(rv[14]), 32'h00000000);
        three_loads;
        rd(`PLC_ADDR_STATE);
        chk(32'(rv[14]), 32'h00000001);
    end
    endtask

    // nothing reloaded: a bare select runs the same entries again
    task s_restart;
    begin
        mode_cmd <= `PLC_MODE_NONE;
        tgt <= 32'h00000000;
        wait_for(2);
        mode_cmd <= `PLC_MODE_SPEED;
        wr(`PLC_ADDR_SEL, 32'h00000001);
        rd(`PLC_ADDR_LAST);
        chk(rv, 32'h0000ffff);
        three_loads;
    end
    endtask

    task s_switch;
    begin
        mode_cmd <= `PLC_MODE_NONE;
        tgt <= 32'h00000000;
        wait_for(2);
        mode_cmd <= `PLC_MODE_PTP;
        wr(`PLC_ADDR_SEL, 32'h00000001);
        tgt <= 32'h00000096;
        wait_for(0);
        chk(32'(speed_setpoint_q), 32'h0000000b);
        wait_for(2);
        wr(`PLC_ADDR_SEL, 32'h00000002);
        tgt <= 32'h0000047e;
        wait_for(2);
        chk(32'(trigger_oe_q), 32'h00000001);
        chk(32'(speed_setpoint_q), 32'h0000000b);
        rd(`PLC_ADDR_LAST);
        chk(rv, 32'h00000000);
        tgt <= 32'h000004e2;
        wait_for(2);
        chk(32'(trigger_oe_q), 32'h00000000);
        wr(`PLC_ADDR_SEL, 32'h00000000);
        rd(`PLC_ADDR_STATE);
        chk(32'(rv[14]), 32'h00000001);
        tgt <= 32'h000013ec;
        wait_for(2);
        chk(32'(trigger_oe_q), 32'h00000000);
    end
    endtask

    // bad range refused, speed list runs but loads nothing in gear, signal list acts there
    task s_refuse;
    begin
        wr(`PLC_ADDR_START1, 32'h00000005);
        wr(`PLC_ADDR_SEL, 32'h00000001);
        rd(`PLC_ADDR_STATE);
        chk(rv, 32'h0000c000);
        wr(`PLC_ADDR_START1, 32'h00000002);
        mode_cmd <= `PLC_MODE_GEAR;
        wr(`PLC_ADDR_SEL, 32'h00000001);
        rd(`PLC_ADDR_STATE);
        chk(rv, 32'h00000001);
        tgt <= 32'h00000050;
        wait_for(2);
        chk(32'(speed_setpoint_q), 32'h0000000b);
        rd(`PLC_ADDR_LAST);
        chk(rv, 32'h0000ffff);
        wr(`PLC_ADDR_SEL, 32'h00000002);
        tgt <= 32'h0000047e;
        wait_for(2);
        chk(32'(trigger_oe_q), 32'h00000001);
        wr(`PLC_ADDR_SEL, 32'h00000003);
        rd(`PLC_ADDR_STATE);
        chk(rv, 32'h00004000);
    end
    endtask

    initial
    begin
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        s_reset;
        s_load;
        s_speed;
        s_restart;
        s_switch;
        s_refuse;
        end_sim;
    end
endmodule
